// ==== pkg/hcru_pkg.sv ====
// Notes on behaviour
// RQ1: Register A reads at 0AH; a write lands only straight after a read of 0AH.
// RQ2: A write to 0AH after any intervening access goes to remote byte count 0.
// RQ3: Register B reads at 0BH; a write lands only straight after a read of 0BH.
// RQ4: A write to 0BH after any intervening access goes to remote byte count 1.
// RQ5: Base field decodes 000/010/011/100/101/110/111 to 300/240/280/2C0/320/340/360 hex.
// RQ6: The device answers a window of 20H bytes from the chosen base.
// RQ7: Base field 001 answers no I/O address and enables software configuration.
// RQ8: In software mode four consecutive writes to 278H load the base bits.
// RQ9: The software load works once per power-on reset; later tries are ignored.
// RQ10: Bit 5 of register C picks direct-drive or coded interrupt mode.
// RQ11: Direct-drive mode drives one interrupt pin; the other three float.
// RQ12: Direct-drive pin is chosen by register A bits 4 and 3; bit 5 ignored.
// RQ13: Coded mode uses pin 3 as interrupt; pins 0 to 2 show bits 3 to 5.
// RQ14: Early fetch in I/O mode starts the next port fetch during the current read.
// RQ15: Register A bit 7 high means shared memory, low means I/O port mode.
// RQ16: Host must not update register B by read, OR and write back.
// RQ17: Writing one to the bus fault bit clears it; writing zero keeps it.
// RQ18: Writing one to link test disables it; reading returns link status.
// RQ19: Any other register access, read or write, drops the unlock tracking.
package hcru_pkg;
   localparam logic [3:0] OFS_CFG_A = 4'h_a;
   localparam logic [3:0] OFS_CFG_B = 4'h_b;
   localparam logic [9:0] SW_CFG_PORT = 10'h_0278;
   localparam logic [9:0] WINDOW_SIZE = 10'h_0020;
   localparam logic [2:0] BASE_SOFTWARE = 3'h_1;
   localparam logic [7:0] CFG_A_RESET = 8'h_00;
   localparam logic [7:0] CFG_B_RESET = 8'h_00;
   localparam int SW_WRITE_COUNT = 4;
   localparam int BIT_BUS_FAULT = 5;
   localparam int BIT_LINK_TEST = 2;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] ofs;
      logic [7:0] wdata;
   } hcru_reg_req_t;

   typedef struct packed {
      logic shared_memory_select;
      logic early_port_fetch;
      logic [2:0] irq_line_select;
      logic [2:0] base_io_select;
   } hcru_cfg_a_t;
endpackage

// ==== core/hcru_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcru_top (
   input wire logic clk, // 10 MHz clock.
   input wire logic resetn, // Synchronous power-on reset.
   input wire hcru_pkg::hcru_reg_req_t req, // Page-0 register access strobes.
   input wire logic io_wr, // Raw host I/O write strobe.
   input wire logic [9:0] io_addr, // Host I/O address.
   input wire logic [7:0] io_wdata, // Host I/O write data.
   input wire logic cfg_c_irq_coded, // Register C bit 5 level.
   input wire logic irq_event, // Interrupt condition from controller.
   input wire logic link_status, // Current link integrity status.
   input wire logic bus_fault_event, // Bus error detected pulse.
   input wire logic port_read_active, // Host data-port read in progress.
   output logic [7:0] rdata, // Read data for 0AH and 0BH.
   output logic rdata_hit, // Read addressed a hidden register.
   output logic rbc0_wr, // Write steered to remote byte count 0.
   output logic rbc1_wr, // Write steered to remote byte count 1.
   output logic [7:0] rbc_wdata, // Data for the steered write.
   output logic io_select, // Address falls in the device window.
   output logic [9:0] io_base, // Decoded base I/O address.
   output logic [3:0] irq_out, // Interrupt pin levels.
   output logic [3:0] irq_oe, // Interrupt pin drive enables.
   output logic early_fetch_start, // Begin next port fetch early.
   output logic shared_memory_mode, // Shared memory selected.
   output logic link_test_disable, // Link pulses and checking off.
   output logic [7:0] cfg_b_out // Register B control bits.
);
   hcru_pkg::hcru_cfg_a_t cfg_a_q;
   logic [7:0] cfg_b_q;
   logic unlock_a_q, unlock_b_q;
   logic [1:0] sw_cnt_q;
   logic sw_done_q;
   logic [9:0] base_d;
   logic any_acc;
   logic wr_a_ok, wr_b_ok;

   assign any_acc = req.rd | req.wr;
   assign wr_a_ok = req.wr && req.ofs == hcru_pkg::OFS_CFG_A && unlock_a_q; // RQ1
   assign wr_b_ok = req.wr && req.ofs == hcru_pkg::OFS_CFG_B && unlock_b_q; // RQ3

   always_ff @(posedge clk) begin
      if (!resetn) begin
         unlock_a_q <= 1'b0;
         unlock_b_q <= 1'b0;
      end else if (any_acc) begin
         unlock_a_q <= req.rd && req.ofs == hcru_pkg::OFS_CFG_A; // RQ19
         unlock_b_q <= req.rd && req.ofs == hcru_pkg::OFS_CFG_B; // RQ19
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rbc0_wr <= 1'b0;
         rbc1_wr <= 1'b0;
         rbc_wdata <= 8'h_00;
      end else begin
         rbc0_wr <= req.wr && req.ofs == hcru_pkg::OFS_CFG_A && !unlock_a_q; // RQ2
         rbc1_wr <= req.wr && req.ofs == hcru_pkg::OFS_CFG_B && !unlock_b_q; // RQ4
         rbc_wdata <= req.wdata;
      end
   end

   // Software load: consecutive writes to the port, counted only while the base field is 001 and no load is done.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_a_q <= hcru_pkg::hcru_cfg_a_t'(hcru_pkg::CFG_A_RESET);
         sw_cnt_q <= 2'h_0;
         sw_done_q <= 1'b0;
      end else begin
         if (wr_a_ok) begin
            cfg_a_q <= hcru_pkg::hcru_cfg_a_t'(req.wdata); // RQ1
         end
         if (cfg_a_q.base_io_select == hcru_pkg::BASE_SOFTWARE && !sw_done_q && io_wr) begin
            if (io_addr == hcru_pkg::SW_CFG_PORT) begin // RQ8
               if (sw_cnt_q == 2'(hcru_pkg::SW_WRITE_COUNT - 1)) begin
                  cfg_a_q.base_io_select <= io_wdata[2:0]; // RQ8
                  sw_done_q <= 1'b1; // RQ9
                  sw_cnt_q <= 2'h_0;
               end else begin
                  sw_cnt_q <= sw_cnt_q + 2'h_1;
               end
            end else begin
               sw_cnt_q <= 2'h_0;
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cfg_b_q <= hcru_pkg::CFG_B_RESET;
      end else begin
         if (wr_b_ok) begin
            cfg_b_q <= req.wdata;
            cfg_b_q[hcru_pkg::BIT_BUS_FAULT] <= cfg_b_q[hcru_pkg::BIT_BUS_FAULT]
               & ~req.wdata[hcru_pkg::BIT_BUS_FAULT]; // RQ17
         end
         if (bus_fault_event) begin
            cfg_b_q[hcru_pkg::BIT_BUS_FAULT] <= 1'b1;
         end
      end
   end

   always_comb begin
      case (cfg_a_q.base_io_select) // RQ5
         3'h_0: base_d = 10'h_0300;
         3'h_2: base_d = 10'h_0240;
         3'h_3: base_d = 10'h_0280;
         3'h_4: base_d = 10'h_02c0;
         3'h_5: base_d = 10'h_0320;
         3'h_6: base_d = 10'h_0340;
         3'h_7: base_d = 10'h_0360;
         default: base_d = 10'h_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         io_base <= 10'h_0000;
         io_select <= 1'b0;
      end else begin
         io_base <= base_d;
         io_select <= cfg_a_q.base_io_select != hcru_pkg::BASE_SOFTWARE // RQ7
            && io_addr >= base_d && io_addr < base_d + hcru_pkg::WINDOW_SIZE; // RQ6
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         irq_out <= 4'h_0;
         irq_oe <= 4'h_0;
      end else if (cfg_c_irq_coded) begin // RQ10
         irq_out <= {irq_event, cfg_a_q.irq_line_select}; // RQ13
         irq_oe <= 4'h_f;
      end else begin
         irq_out <= 4'h_0;
         irq_oe <= 4'h_0;
         irq_out[cfg_a_q.irq_line_select[1:0]] <= irq_event; // RQ12
         irq_oe[cfg_a_q.irq_line_select[1:0]] <= 1'b1; // RQ11
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rdata <= 8'h_00;
         rdata_hit <= 1'b0;
         early_fetch_start <= 1'b0;
         shared_memory_mode <= 1'b0;
         link_test_disable <= 1'b0;
         cfg_b_out <= 8'h_00;
      end else begin
         rdata_hit <= req.rd && (req.ofs == hcru_pkg::OFS_CFG_A || req.ofs == hcru_pkg::OFS_CFG_B);
         if (req.ofs == hcru_pkg::OFS_CFG_A) begin
            rdata <= cfg_a_q; // RQ1
         end else begin
            rdata <= cfg_b_q; // RQ3
            rdata[hcru_pkg::BIT_LINK_TEST] <= link_status; // RQ18
         end
         early_fetch_start <= cfg_a_q.early_port_fetch && !cfg_a_q.shared_memory_select
            && port_read_active; // RQ14
         shared_memory_mode <= cfg_a_q.shared_memory_select; // RQ15
         link_test_disable <= cfg_b_q[hcru_pkg::BIT_LINK_TEST]; // RQ18
         cfg_b_out <= cfg_b_q;
      end
   end

   a_unlock_write_a: assert property (@(posedge clk) disable iff (!resetn)
      (req.wr && req.ofs == hcru_pkg::OFS_CFG_A && !unlock_a_q) |=> rbc0_wr) // RQ2
      else $error("write without read did not go to byte count 0");
   a_unlock_write_b: assert property (@(posedge clk) disable iff (!resetn)
      (req.wr && req.ofs == hcru_pkg::OFS_CFG_B && !unlock_b_q) |=> rbc1_wr) // RQ4
      else $error("write without read did not go to byte count 1");
   a_cfg_a_load: assert property (@(posedge clk) disable iff (!resetn)
      wr_a_ok && !io_wr |=> cfg_a_q == $past(req.wdata)) // RQ1
      else $error("register A did not take unlocked write");
   a_window_soft: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.base_io_select == hcru_pkg::BASE_SOFTWARE |=> !io_select) // RQ7
      else $error("device answered in software mode");
   a_irq_one_pin: assert property (@(posedge clk) disable iff (!resetn)
      !cfg_c_irq_coded |=> $onehot(irq_oe)) // RQ11
      else $error("direct mode drives not exactly one pin");
   a_irq_coded: assert property (@(posedge clk) disable iff (!resetn)
      cfg_c_irq_coded |=> irq_out[2:0] == $past(cfg_a_q.irq_line_select)) // RQ13
      else $error("coded pins do not follow register A");
   a_sw_once: assert property (@(posedge clk) disable iff (!resetn)
      sw_done_q && !wr_a_ok |=> cfg_a_q.base_io_select == $past(cfg_a_q.base_io_select)) // RQ9
      else $error("base bits changed after software load");
   a_fault_clear: assert property (@(posedge clk) disable iff (!resetn)
      wr_b_ok && req.wdata[hcru_pkg::BIT_BUS_FAULT] && !bus_fault_event
      |=> !cfg_b_q[hcru_pkg::BIT_BUS_FAULT]) // RQ17
      else $error("bus fault not cleared by one");
   a_shared_mode: assert property (@(posedge clk) disable iff (!resetn)
      ##1 shared_memory_mode == $past(cfg_a_q.shared_memory_select)) // RQ15
      else $error("shared memory mode wrong");

   sequence s_read_a;
      req.rd && req.ofs == hcru_pkg::OFS_CFG_A;
   endsequence

   sequence s_write_a;
      req.wr && req.ofs == hcru_pkg::OFS_CFG_A;
   endsequence

   sequence s_read_b;
      req.rd && req.ofs == hcru_pkg::OFS_CFG_B;
   endsequence

   sequence s_write_b;
      req.wr && req.ofs == hcru_pkg::OFS_CFG_B;
   endsequence

   // A read, one idle cycle and a write to the same offset form an unlocked pair.
   a_pair_lands_a: assert property (@(posedge clk) disable iff (!resetn)
      s_read_a ##1 !any_acc ##1 s_write_a ##0 !io_wr
      |=> !rbc0_wr && cfg_a_q == $past(req.wdata)) // RQ1
      else $error("paired write did not reach register A");

   a_pair_lands_b: assert property (@(posedge clk) disable iff (!resetn)
      s_read_b ##1 !any_acc ##1 s_write_b
      |=> !rbc1_wr && cfg_b_q[1:0] == $past(req.wdata[1:0])) // RQ3
      else $error("paired write did not reach register B");

   a_other_drops_a: assert property (@(posedge clk) disable iff (!resetn)
      s_read_a ##2 (any_acc && !(req.rd && req.ofs == hcru_pkg::OFS_CFG_A)) ##2 s_write_a
      |=> rbc0_wr) // RQ2 RQ19
      else $error("intervening access did not drop unlock of A");

   a_other_drops_b: assert property (@(posedge clk) disable iff (!resetn)
      s_read_b ##2 (any_acc && !(req.rd && req.ofs == hcru_pkg::OFS_CFG_B)) ##2 s_write_b
      |=> rbc1_wr) // RQ4 RQ19
      else $error("intervening access did not drop unlock of B");

   a_steered_data: assert property (@(posedge clk) disable iff (!resetn)
      s_write_a ##0 !unlock_a_q
      |=> rbc_wdata == $past(req.wdata)) // RQ2
      else $error("steered write carries wrong data");

   a_read_a_data: assert property (@(posedge clk) disable iff (!resetn)
      req.rd && req.ofs == hcru_pkg::OFS_CFG_A
      |=> rdata_hit && rdata == $past(cfg_a_q)) // RQ1
      else $error("read of register A returned wrong data");

   a_read_b_link: assert property (@(posedge clk) disable iff (!resetn)
      req.rd && req.ofs == hcru_pkg::OFS_CFG_B
      |=> rdata_hit && rdata[hcru_pkg::BIT_LINK_TEST] == $past(link_status)) // RQ18
      else $error("read of register B lacks link status");

   a_fault_set: assert property (@(posedge clk) disable iff (!resetn)
      bus_fault_event
      |=> cfg_b_q[hcru_pkg::BIT_BUS_FAULT]) // RQ17
      else $error("bus fault event not recorded");

   a_fault_hold: assert property (@(posedge clk) disable iff (!resetn)
      wr_b_ok && !req.wdata[hcru_pkg::BIT_BUS_FAULT] && cfg_b_q[hcru_pkg::BIT_BUS_FAULT]
      |=> cfg_b_q[hcru_pkg::BIT_BUS_FAULT]) // RQ17
      else $error("writing zero cleared bus fault");

   a_link_disable: assert property (@(posedge clk) disable iff (!resetn)
      wr_b_ok && req.wdata[hcru_pkg::BIT_LINK_TEST]
      |-> ##2 link_test_disable) // RQ18
      else $error("link test not disabled by one");

   a_base_decode: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.base_io_select == 3'h_2
      |=> io_base == 10'h_0240) // RQ5
      else $error("base field 010 decoded wrongly");

   a_soft_base: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.base_io_select == hcru_pkg::BASE_SOFTWARE
      |=> io_base == 10'h_0000) // RQ7
      else $error("software mode shows a base address");

   a_window_hit: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.base_io_select == 3'h_0 && io_addr == 10'h_031f
      |=> io_select) // RQ6
      else $error("last window address not selected");

   a_window_edge: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.base_io_select == 3'h_0 && io_addr == 10'h_0320
      |=> !io_select) // RQ6
      else $error("address past window selected");

   a_direct_pin: assert property (@(posedge clk) disable iff (!resetn)
      !cfg_c_irq_coded
      |=> irq_oe[$past(cfg_a_q.irq_line_select[1:0])] && irq_out[$past(cfg_a_q.irq_line_select[1:0])] == $past(irq_event)) // RQ12
      else $error("direct mode drives the wrong pin");

   a_coded_drive: assert property (@(posedge clk) disable iff (!resetn)
      cfg_c_irq_coded
      |=> irq_oe == 4'h_f && irq_out[3] == $past(irq_event)) // RQ13
      else $error("coded mode pin 3 wrong");

   a_early_fetch: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.early_port_fetch && !cfg_a_q.shared_memory_select && port_read_active
      |=> early_fetch_start) // RQ14
      else $error("early fetch not started");

   a_shared_no_fetch: assert property (@(posedge clk) disable iff (!resetn)
      cfg_a_q.shared_memory_select
      |=> !early_fetch_start) // RQ15
      else $error("early fetch in shared memory mode");
endmodule
`default_nettype wire

// ==== dv/hcru_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module hcru_host (
   input wire logic clk, // Bus clock.
   output var hcru_pkg::hcru_reg_req_t req, // Register access strobes.
   output logic io_wr, // Raw I/O write strobe.
   output logic [9:0] io_addr, // Raw I/O address.
   output logic [7:0] io_wdata // Raw I/O write data.
);
   initial begin
      req = '0;
      io_wr = 1'b0;
      io_addr = 10'h_0000;
      io_wdata = 8'h_00;
   end
   // Register B is always written whole, never read, OR-ed and written back.
   task automatic acc(input logic r, input logic [3:0] o, input logic [7:0] d);
      @(posedge clk);
      req <= '{rd: r, wr: !r, ofs: o, wdata: d};
      @(posedge clk);
      req <= '{rd: 1'b0, wr: 1'b0, ofs: ~o, wdata: ~d};
      #1;
   endtask
   task automatic iow(input logic [9:0] a, input logic [7:0] d);
      @(posedge clk);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge clk);
      io_wr <= 1'b0;
      io_wdata <= ~d;
      #1;
   endtask
   task automatic probe(input logic [9:0] a);
      @(posedge clk);
      io_addr <= a;
      repeat (2) @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [3:0] RA = hcru_pkg::OFS_CFG_A;
   localparam logic [3:0] RB = hcru_pkg::OFS_CFG_B;
   logic clk, resetn, cfg_c_irq_coded, irq_event, link_status, bus_fault_event, port_read_active;
   hcru_pkg::hcru_reg_req_t req;
   logic io_wr, rdata_hit, rbc0_wr, rbc1_wr, io_select, early_fetch_start, shared_memory_mode, link_test_disable;
   logic [9:0] io_addr, io_base;
   logic [7:0] io_wdata, rdata, rbc_wdata, cfg_b_out;
   logic [3:0] irq_out, irq_oe;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [9:0] bases [8] = '{10'h_0300, 10'h_0000, 10'h_0240, 10'h_0280, 10'h_02c0, 10'h_0320, 10'h_0340, 10'h_0360};
   hcru_top hcru_top_inst (.clk, .resetn, .req, .io_wr, .io_addr, .io_wdata, .cfg_c_irq_coded, .irq_event,
      .link_status, .bus_fault_event, .port_read_active, .rdata, .rdata_hit, .rbc0_wr, .rbc1_wr, .rbc_wdata,
      .io_select, .io_base, .irq_out, .irq_oe, .early_fetch_start, .shared_memory_mode, .link_test_disable,
      .cfg_b_out);
   hcru_host hcru_host_inst (.clk, .req, .io_wr, .io_addr, .io_wdata);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd_chk(input logic [3:0] o, input logic [7:0] e);
      hcru_host_inst.acc(1'b1, o, 8'h_00);
      chk("rdata", {8'h_00, e}, {8'h_00, rdata});
      chk("rdata_hit", 16'h_0001, {15'h_0000, rdata_hit});
   endtask
   task automatic wr_chk(input logic [3:0] o, input logic [7:0] d, input logic [1:0] e);
      hcru_host_inst.acc(1'b0, o, d);
      chk("rbc_wr", {14'h_0000, e}, {14'h_0000, rbc1_wr, rbc0_wr});
      if (e != 2'b00) chk("rbc_wdata", {8'h_00, d}, {8'h_00, rbc_wdata});
   endtask
   task automatic set_a(input logic [7:0] d);
      hcru_host_inst.acc(1'b1, RA, 8'h_00);
      wr_chk(RA, d, 2'b00);
      repeat (2) @(posedge clk);
      #1;
   endtask
   initial begin
      resetn = 1'b0;
      cfg_c_irq_coded = 1'b0;
      irq_event = 1'b0;
      link_status = 1'b1;
      bus_fault_event = 1'b0;
      port_read_active = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      rd_chk(RA, hcru_pkg::CFG_A_RESET);
      rd_chk(RB, 8'h_04);
      wr_chk(RA, 8'h_5a, 2'b01);
      hcru_host_inst.acc(1'b1, RA, 8'h_00);
      repeat (2) @(posedge clk);
      wr_chk(RA, 8'h_40, 2'b00);
      rd_chk(RA, 8'h_40);
      rd_chk(RB, 8'h_04);
      wr_chk(RA, 8'h_11, 2'b01);
      hcru_host_inst.acc(1'b1, RA, 8'h_00);
      wr_chk(RB, 8'h_00, 2'b10);
      rd_chk(RB, 8'h_04);
      wr_chk(RB, 8'h_04, 2'b00);
      @(posedge clk);
      #1;
      chk("link_test_disable", 16'h_0001, {15'h_0000, link_test_disable});
      chk("cfg_b_out", 16'h_0004, {8'h_00, cfg_b_out});
      @(posedge clk);
      link_status <= 1'b0;
      @(posedge clk);
      bus_fault_event <= 1'b1;
      @(posedge clk);
      bus_fault_event <= 1'b0;
      rd_chk(RB, 8'h_20);
      wr_chk(RB, 8'h_00, 2'b00);
      rd_chk(RB, 8'h_20);
      wr_chk(RB, 8'h_20, 2'b00);
      rd_chk(RB, 8'h_00);
      $display("test unlock done, mismatches %0d", error_cnt);
      for (int i = 0; i < 8; i++) begin
         if (i == 1) continue;
         set_a(8'(i));
         hcru_host_inst.probe(bases[i] + 10'h_001f);
         chk("io_base", {6'h_00, bases[i]}, {6'h_00, io_base});
         chk("io_select in", 16'h_0001, {15'h_0000, io_select});
         hcru_host_inst.probe(bases[i] + hcru_pkg::WINDOW_SIZE);
         chk("io_select out", 16'h_0000, {15'h_0000, io_select});
      end
      $display("test decode done, mismatches %0d", error_cnt);
      @(posedge clk);
      irq_event <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         set_a({2'b00, 1'b1, 2'(s), 3'b000});
         chk("irq_oe", {12'h_000, 4'b0001 << s}, {12'h_000, irq_oe});
         chk("irq_out", {12'h_000, 4'b0001 << s}, {12'h_000, irq_out & irq_oe});
      end
      cfg_c_irq_coded <= 1'b1;
      set_a(8'h_28);
      chk("coded oe", 16'h_000f, {12'h_000, irq_oe});
      chk("coded out", 16'h_000d, {12'h_000, irq_out});
      $display("test irq done, mismatches %0d", error_cnt);
      port_read_active <= 1'b1;
      set_a(8'h_40);
      chk("early_fetch_start", 16'h_0001, {15'h_0000, early_fetch_start});
      chk("shared io", 16'h_0000, {15'h_0000, shared_memory_mode});
      set_a(8'h_80);
      chk("shared mem", 16'h_0001, {15'h_0000, shared_memory_mode});
      $display("test mode done, mismatches %0d", error_cnt);
      set_a(8'h_01);
      hcru_host_inst.probe(10'h_0300);
      chk("sw select", 16'h_0000, {15'h_0000, io_select});
      chk("sw base", 16'h_0000, {6'h_00, io_base});
      for (int k = 0; k < hcru_pkg::SW_WRITE_COUNT; k++) hcru_host_inst.iow(hcru_pkg::SW_CFG_PORT, 8'h_02);
      repeat (2) @(posedge clk);
      #1;
      chk("sw load", 16'h_0240, {6'h_00, io_base});
      set_a(8'h_01);
      for (int k = 0; k < hcru_pkg::SW_WRITE_COUNT; k++) hcru_host_inst.iow(hcru_pkg::SW_CFG_PORT, 8'h_06);
      repeat (2) @(posedge clk);
      #1;
      chk("sw once", 16'h_0000, {6'h_00, io_base});
      $display("test software done, mismatches %0d", error_cnt);
      give_verdict();
   end
endmodule
`default_nettype wire
